// ---- rtl/uftc_pkg.sv ----
// Constants and carriers for the serial queue time-out and fallback control
package uftc_pkg;
  localparam int MCLK_KHZ = 20000;
  localparam int TO_US = 64;
  localparam int US_CYC = MCLK_KHZ / 1000;
  localparam int CHAR_TO = 4;
  localparam int DEFER_LVL = 14;
  localparam int LVL_STD = 16;
  localparam int LVL_DEEP = 32;
  localparam int THR_L0 = 1;
  localparam int THR_L1 = 4;
  localparam int THR_L2 = 8;
  localparam int THR_L3 = 14;
  localparam int TW = 7;
  localparam logic [TW-1:0] T_MAX = 7'h7F;
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_EIR = 3'h2;
  localparam logic [2:0] OFF_LCR = 3'h3;
  localparam logic [2:0] OFF_MCR = 3'h4;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_MSR = 3'h6;
  localparam logic [2:0] OFF_ASC = 3'h7;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [1:0] BANK2 = 2'h2;
  localparam int LCR_BK_HI = 7;
  localparam int LCR_BK_LO = 6;
  localparam int IER_RXDR = 0;
  localparam int IER_EXT_LO = 4;
  localparam int MCR_RXDMA = 2;
  localparam int MCR_DEFER = 4;
  localparam int MCR_MODE = 5;
  localparam int ASC_TO = 0;
  localparam int ASC_ACT = 1;
  localparam int FCR_EN = 0;
  localparam int FCR_THR = 6;
  localparam int EXC1_EXT = 0;
  localparam int EXC1_LBK = 5;
  localparam int EXC1_BT = 6;
  localparam int EXC2_DEEP = 2;
  localparam int EXC2_PRE = 4;
  localparam int EXC2_LOCK = 7;
  localparam int CFG4_AUTO = 7;
  localparam int CFG4_D0 = 6;
  localparam int CFG4_D21 = 5;
  localparam int CFG1_UART = 4;
  localparam int LSR_DR = 0;
  localparam int LSR_OVR = 1;
  localparam int LSR_TQE = 5;
  localparam int LSR_TE = 6;
  localparam logic [1:0] PRESC_13 = 2'h0;
  localparam logic [3:0] EIR_NONE = 4'h1;
  localparam logic [2:0] EIR_RXDR = 3'h4;
  typedef enum logic [2:0] {
    MODE_UART = 3'h0,
    MODE_ALTIR = 3'h1,
    MODE_SIR = 3'h2,
    MODE_CIR = 3'h4
  } uftc_mode_t;
  typedef enum logic {DF_OPEN = 1'b0, DF_HELD = 1'b1} uftc_defer_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uftc_bus_t;
  typedef struct packed {
    logic rx_ack;
    logic tx_ack;
    logic [7:0] tx_data;
  } uftc_dma_t;
endpackage : uftc_pkg

// ---- rtl/uftc_tick.sv ----
// Microsecond enable pulse divided down from the module clock
`timescale 1ns/100ps
module uftc_tick #(parameter int CLK_PER_US = uftc_pkg::US_CYC) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // One-cycle pulse each microsecond
  output logic us_tick
);
  typedef struct packed {logic [7:0] cnt; logic tick;} uftc_tk_t;
  uftc_tk_t s, n;
  if (CLK_PER_US < 1 || CLK_PER_US > 256) begin : g_chk
    $error("CLK_PER_US out of range");
  end
  always_comb begin
    n = s;
    n.tick = (s.cnt == 8'(CLK_PER_US - 1));
    n.cnt = n.tick ? 8'h00 : s.cnt + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign us_tick = s.tick;
endmodule : uftc_tick

// ---- rtl/uftc_ram.sv ----
// Queue storage with registered, write-through read port
`timescale 1ns/100ps
module uftc_ram #(parameter int AW = 5) (
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] q
);
  logic [7:0] mem [2**AW];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    q <= (we && waddr == raddr) ? wdata : mem[raddr];
  end
endmodule : uftc_ram

// ---- rtl/uftc_top.sv ----
// Queue time-outs, transmit deferral, fallback and transceiver pins
//
// What this block does
// - Time-out raises data-ready interrupt (enable bit 0), DMA request (bit 2)
// - Time-out shows in aux status bit 0 only while queue below threshold
// - Time-out stays set until the receive queue is read
// - Two timers: 64 us and four character times
// - Event A: byte held, greater period since load and read; interrupt, flag
// - Event B: same with smaller period; DMA request only, hidden from software
// - Consumer-infrared: no time-out while the receiver is active
// - Consumer-infrared: 64 us resident, 64 us inactive, over 64 us since read
// - Deferral only in extended mode with the transmit queue enabled
// - Empty transmitter locks; release when queue level reaches 14
// - Lock timer reloads per byte, releases after 64 us idle
// - Any access of a legacy divisor port triggers fallback, except with the lock bit set in legacy mode
// - Alternate divisor ports never trigger fallback
// - Fallback: 16 levels, prescaler 13, clear tests, UART, leave extended
// - Low-rate and alternate infrared stay selected on fallback; consumer-infrared goes to UART
// - Lock bit in legacy mode: no fallback, divisor ports become scratch
// - Three select pins and an id input, all inputs after reset
// - Select outputs follow config one, or preset levels on mode change
// - Two direction bits steer select pin 0 and pins 2 and 1
// - Reset gives legacy bank 0; extended adds features except data port
// - Data port reads receive queue bottom, writes load transmit queue
// - DMA always reaches the data ports whatever bank is selected
// - Consumer-infrared receiver going active sets the active flag
`timescale 1ns/100ps
module uftc_top #(parameter int FIFO_AW = 5) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire uftc_pkg::uftc_bus_t bus,
  output logic [7:0] rdata,
  // Receiver side
  input wire logic rx_load,
  input wire logic [7:0] rx_byte,
  input wire logic char_tick,
  input wire logic rx_went_active,
  // Transmitter side
  input wire logic tx_pop,
  input wire logic tx_idle,
  output logic tx_valid,
  output logic [7:0] tx_data,
  // DMA
  input wire uftc_pkg::uftc_dma_t dma,
  output logic rx_dma_req,
  output logic [7:0] rx_dma_data,
  // Settings toward the rest of the module
  output logic rx_irq,
  output logic ext_mode,
  output logic [2:0] op_mode,
  output logic [15:0] baud_divisor,
  output logic [1:0] prescale_sel,
  // Transceiver pins
  input wire logic [2:0] xcvr_sel_in,
  input wire logic xcvr_id_input,
  output logic [2:0] xcvr_sel_out,
  output logic [2:0] xcvr_sel_oe_n
);
  import uftc_pkg::*;
  localparam int CW = FIFO_AW + 1;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic fen;
    logic [1:0] thr;
    logic [7:0] lcr;
    logic [7:0] modem_control;
    logic [7:0] scr;
    logic [7:0] exc1;
    logic [7:0] exc2;
    logic [7:0] cfg1;
    logic [7:0] cfg4;
    logic [15:0] div;
    logic [15:0] lscr;
    logic [FIFO_AW-1:0] rx_wp;
    logic [FIFO_AW-1:0] rx_rp;
    logic [CW-1:0] rx_cnt;
    logic [FIFO_AW-1:0] tx_wp;
    logic [FIFO_AW-1:0] tx_rp;
    logic [CW-1:0] tx_cnt;
    logic ovr;
    logic to_a;
    logic to_b;
    logic act;
    logic [TW-1:0] us_lr;
    logic [TW-1:0] ch_lr;
    logic [TW-1:0] us_rd;
    logic [TW-1:0] us_res;
    logic [TW-1:0] us_idle;
    logic [TW-1:0] dly;
    uftc_defer_t dfs;
    logic [2:0] auto_lvl;
    logic [2:0] prev_mode;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [7:0] rdata;
  } uftc_st_t;

  uftc_st_t s, n;
  logic us_tick;
  logic [7:0] rx_q;
  logic [1:0] bank;
  logic ext, cir, scr_on, leg, fb, dok;
  logic data_rd, cpu_tw, rx_push, rx_pop, tx_push, tx_take;
  logic rx_hi, set_a, set_b;
  int cap;

  if (FIFO_AW < 5) begin : g_chk
    $error("FIFO_AW must hold 32 entries");
  end

  function automatic logic [1:0] bank_of(input logic [7:0] lcr);
    if (!lcr[LCR_BK_HI]) begin
      return BANK0;
    end
    return lcr[LCR_BK_LO] ? BANK2 : BANK1;
  endfunction : bank_of

  function automatic int lvl_of(input logic fen, input logic [1:0] thr);
    if (!fen) begin
      return THR_L0;
    end
    unique case (thr)
      2'h0: return THR_L0;
      2'h1: return THR_L1;
      2'h2: return THR_L2;
      2'h3: return THR_L3;
    endcase
  endfunction : lvl_of

  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v,
                                            input logic en);
    return (en && v != T_MAX) ? v + TW'(1) : v;
  endfunction : sat_inc

  uftc_tick u_tick (
    .mclk(mclk),
    .srst(srst),
    .us_tick(us_tick)
  );

  uftc_ram #(.AW(FIFO_AW)) u_rxq (
    .mclk(mclk),
    .we(rx_push),
    .waddr(s.rx_wp),
    .wdata(rx_byte),
    .raddr(n.rx_rp),
    .q(rx_q)
  );

  uftc_ram #(.AW(FIFO_AW)) u_txq (
    .mclk(mclk),
    .we(tx_push),
    .waddr(s.tx_wp),
    .wdata(cpu_tw ? bus.wdata : dma.tx_data),
    .raddr(n.tx_rp),
    .q(tx_data)
  );

  // Bus decode and queue strobes
  assign bank = bank_of(s.lcr);
  assign ext = s.exc1[EXC1_EXT];
  assign cir = (s.modem_control[MCR_MODE+:3] == MODE_CIR);
  assign scr_on = !ext && s.exc2[EXC2_LOCK];
  assign leg = (bus.wr || bus.rd) && bank == BANK1 &&
               (bus.addr == OFF_DATA || bus.addr == OFF_IER);
  assign fb = leg && !scr_on;
  assign data_rd = bus.rd && bank == BANK0 && bus.addr == OFF_DATA;
  assign cpu_tw = bus.wr && bank == BANK0 && bus.addr == OFF_DATA;
  assign cap = !s.fen ? 1 : (s.exc2[EXC2_DEEP] ? LVL_DEEP : LVL_STD);
  assign rx_push = rx_load && int'(s.rx_cnt) < cap;
  assign rx_pop = (data_rd || dma.rx_ack) && s.rx_cnt != '0;
  assign tx_push = (cpu_tw || dma.tx_ack) && int'(s.tx_cnt) < cap;
  assign tx_take = tx_pop && tx_valid;
  assign rx_hi = int'(s.rx_cnt) >= lvl_of(s.fen, s.thr);
  assign dok = ext && s.fen && s.modem_control[MCR_DEFER];

  // Time-out events; a load or read restarts the elapsed time itself
  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    if (s.rx_cnt != '0 && !rx_pop) begin
      if (cir) begin
        set_a = !s.act && int'(s.us_res) >= TO_US &&
                int'(s.us_idle) >= TO_US && int'(s.us_rd) > TO_US;
      end else if (!rx_push) begin
        set_a = int'(s.us_lr) > TO_US && int'(s.ch_lr) > CHAR_TO;
        set_b = int'(s.us_lr) > TO_US || int'(s.ch_lr) > CHAR_TO;
      end
    end
  end

  always_comb begin
    n = s;
    n.pin_s1 = {xcvr_id_input, xcvr_sel_in};
    n.pin_s2 = s.pin_s1;
    // Queue pointers and levels
    if (rx_push) begin
      n.rx_wp = s.rx_wp + FIFO_AW'(1);
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + FIFO_AW'(1);
    end
    n.rx_cnt = s.rx_cnt + CW'(rx_push) - CW'(rx_pop);
    if (tx_push) begin
      n.tx_wp = s.tx_wp + FIFO_AW'(1);
    end
    if (tx_take) begin
      n.tx_rp = s.tx_rp + FIFO_AW'(1);
    end
    n.tx_cnt = s.tx_cnt + CW'(tx_push) - CW'(tx_take);
    // Elapsed-time counters
    n.us_lr = (rx_push || rx_pop) ? '0 : sat_inc(s.us_lr, us_tick);
    n.ch_lr = (rx_push || rx_pop) ? '0 : sat_inc(s.ch_lr, char_tick);
    n.us_rd = rx_pop ? '0 : sat_inc(s.us_rd, us_tick);
    n.us_res = (s.rx_cnt == '0) ? '0 : sat_inc(s.us_res, us_tick);
    n.us_idle = s.act ? '0 : sat_inc(s.us_idle, us_tick);
    n.to_a = set_a || (s.to_a && !rx_pop);
    n.to_b = set_b || (s.to_b && !rx_pop);
    // Transmit deferral lock and its timer
    n.dly = (s.dfs != DF_HELD || s.tx_cnt == '0 || tx_push) ? '0 :
            sat_inc(s.dly, us_tick);
    if (!dok) begin
      n.dfs = DF_OPEN;
    end else if (s.tx_cnt == '0 && tx_idle) begin
      n.dfs = DF_HELD;
    end else if (s.dfs == DF_HELD && (int'(s.tx_cnt) >= DEFER_LVL ||
                                      int'(s.dly) >= TO_US)) begin
      n.dfs = DF_OPEN;
    end
    // Register writes
    if (bus.wr) begin
      case ({bank, bus.addr})
        {BANK0, OFF_IER}: n.interrupt_enable = ext ? bus.wdata : {4'h0, bus.wdata[3:0]};
        {BANK0, OFF_EIR}: begin
          n.fen = bus.wdata[FCR_EN];
          n.thr = bus.wdata[FCR_THR+:2];
        end
        {BANK0, OFF_MCR}: begin
          n.modem_control = ext ? bus.wdata : {s.modem_control[7:5], bus.wdata[4:0]};
        end
        {BANK0, OFF_ASC}: begin
          if (!ext) begin
            n.scr = bus.wdata;
          end else if (bus.wdata[ASC_ACT]) begin
            n.act = 1'b0;
          end
        end
        {BANK1, OFF_DATA}: begin
          if (scr_on) begin
            n.lscr[7:0] = bus.wdata;
          end else begin
            n.div[7:0] = bus.wdata;
          end
        end
        {BANK1, OFF_IER}: begin
          if (scr_on) begin
            n.lscr[15:8] = bus.wdata;
          end else begin
            n.div[15:8] = bus.wdata;
          end
        end
        {BANK2, OFF_DATA}: n.div[7:0] = bus.wdata;
        {BANK2, OFF_IER}: n.div[15:8] = bus.wdata;
        {BANK2, OFF_EIR}: n.exc1 = bus.wdata;
        {BANK2, OFF_MCR}: n.exc2 = bus.wdata;
        {BANK2, OFF_LSR}: n.cfg1 = bus.wdata;
        {BANK2, OFF_MSR}: n.cfg4 = bus.wdata;
        default: begin
          if (bus.addr == OFF_LCR) begin
            n.lcr = bus.wdata;
          end
        end
      endcase
    end
    // Overrun and consumer-infrared activity, set wins over clear
    if (bus.rd && bank == BANK0 && bus.addr == OFF_LSR) begin
      n.ovr = 1'b0;
    end
    if (rx_load && !rx_push) begin
      n.ovr = 1'b1;
    end
    if (rx_went_active && cir) begin
      n.act = 1'b1;
    end
    // Fallback
    if (fb) begin
      n.exc2[EXC2_DEEP] = 1'b0;
      n.exc2[EXC2_PRE+:2] = PRESC_13;
      n.exc1[EXC1_BT] = 1'b0;
      n.exc1[EXC1_LBK] = 1'b0;
      if (ext) begin
        n.exc1[EXC1_EXT] = 1'b0;
        n.interrupt_enable[7:IER_EXT_LO] = 4'h0;
        if (s.modem_control[MCR_MODE+:3] != MODE_SIR &&
            s.modem_control[MCR_MODE+:3] != MODE_ALTIR) begin
          n.modem_control[MCR_MODE+:3] = MODE_UART;
        end
      end
    end
    // Preset pin levels taken on each mode change
    n.prev_mode = s.modem_control[MCR_MODE+:3];
    if (s.prev_mode != s.modem_control[MCR_MODE+:3]) begin
      n.auto_lvl = (s.modem_control[MCR_MODE+:3] == MODE_UART) ?
                   s.cfg1[CFG1_UART+:3] : s.cfg4[2:0];
    end
    // Read data, standing only in the cycle after the strobe
    n.rdata = 8'h00;
    if (bus.rd) begin
      case ({bank, bus.addr})
        {BANK0, OFF_DATA}: n.rdata = rx_q;
        {BANK0, OFF_IER}: n.rdata = s.interrupt_enable;
        {BANK0, OFF_EIR}: begin
          n.rdata = {{2{s.fen}}, 2'b00,
                     rx_irq ? {s.to_a, EIR_RXDR} : EIR_NONE};
        end
        {BANK0, OFF_MCR}: n.rdata = s.modem_control;
        {BANK0, OFF_LSR}: begin
          n.rdata[LSR_DR] = s.rx_cnt != '0;
          n.rdata[LSR_OVR] = s.ovr;
          n.rdata[LSR_TQE] = s.tx_cnt == '0;
          n.rdata[LSR_TE] = s.tx_cnt == '0 && tx_idle;
        end
        {BANK0, OFF_ASC}: begin
          if (ext) begin
            n.rdata[ASC_TO] = s.to_a && !rx_hi;
            n.rdata[ASC_ACT] = s.act;
          end else begin
            n.rdata = s.scr;
          end
        end
        {BANK1, OFF_DATA}: n.rdata = scr_on ? s.lscr[7:0] : s.div[7:0];
        {BANK1, OFF_IER}: n.rdata = scr_on ? s.lscr[15:8] : s.div[15:8];
        {BANK2, OFF_DATA}: n.rdata = s.div[7:0];
        {BANK2, OFF_IER}: n.rdata = s.div[15:8];
        {BANK2, OFF_EIR}: n.rdata = s.exc1;
        {BANK2, OFF_MCR}: n.rdata = s.exc2;
        {BANK2, OFF_LSR}: n.rdata = s.cfg1;
        {BANK2, OFF_MSR}: n.rdata = s.cfg4;
        {BANK2, OFF_ASC}: n.rdata = {4'h0, s.pin_s2};
        default: begin
          if (bus.addr == OFF_LCR) begin
            n.rdata = s.lcr;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign rdata = s.rdata;
  assign rx_dma_data = rx_q;
  assign tx_valid = s.tx_cnt != '0 && s.dfs == DF_OPEN;
  assign rx_irq = s.interrupt_enable[IER_RXDR] && (rx_hi || s.to_a);
  assign rx_dma_req = ext && s.modem_control[MCR_RXDMA] &&
                      (rx_hi || s.to_a || s.to_b);
  assign ext_mode = ext;
  assign op_mode = s.modem_control[MCR_MODE+:3];
  assign baud_divisor = s.div;
  assign prescale_sel = s.exc2[EXC2_PRE+:2];
  assign xcvr_sel_out = s.cfg4[CFG4_AUTO] ? s.auto_lvl : s.cfg1[2:0];
  assign xcvr_sel_oe_n = {{2{!s.cfg4[CFG4_D21]}}, !s.cfg4[CFG4_D0]};

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_irq_timeout: assert property (s.to_a && s.interrupt_enable[IER_RXDR] |-> rx_irq)
    else $error("time-out without interrupt");
  a_to_sticky: assert property (s.to_a && !rx_pop |=> s.to_a)
    else $error("time-out flag dropped without read");
  a_a_elapsed: assert property ($rose(s.to_a) && !$past(cir) |->
    int'($past(s.us_lr)) > TO_US && int'($past(s.ch_lr)) > CHAR_TO)
    else $error("event A before both periods");
  a_b_fast: assert property (!cir && s.rx_cnt != '0 && !rx_pop &&
    !rx_push && int'(s.us_lr) > TO_US |=> s.to_b)
    else $error("event B missed");
  a_cir_active: assert property (cir && s.act && !s.to_a |=> !s.to_a)
    else $error("time-out while receiver active");
  a_defer_hold: assert property (s.dfs == DF_HELD |-> !tx_valid)
    else $error("transmit while locked");
  a_defer_level: assert property (dok && s.dfs == DF_HELD &&
    int'(s.tx_cnt) >= DEFER_LVL |=> s.dfs == DF_OPEN)
    else $error("lock kept at level 14");
  a_defer_timer: assert property (s.dfs == DF_HELD && s.tx_cnt != '0 &&
    int'(s.dly) >= TO_US |=> s.dfs == DF_OPEN)
    else $error("lock kept after idle time");
  a_fallback_ext: assert property (fb && ext |=> !ext_mode &&
    prescale_sel == PRESC_13 && !s.exc2[EXC2_DEEP])
    else $error("fallback incomplete");
  a_lock_scratch: assert property (scr_on && leg |=>
    $stable(baud_divisor) && $stable(s.exc1))
    else $error("locked access changed the baud");

  c_timeout_a: cover property ($rose(s.to_a));
  c_fallback: cover property (fb && ext);
  c_defer_release: cover property (s.dfs == DF_HELD ##1 s.dfs == DF_OPEN);
endmodule : uftc_top

// ---- dv/uftc_host_dma.sv ----
// Host-side DMA controller model serving receive requests
`timescale 1ns/100ps
module uftc_host_dma (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control from the bench
  input wire logic en,
  input wire logic slow,
  // Device side
  input wire logic rx_dma_req,
  input wire logic [7:0] rx_dma_data,
  output uftc_pkg::uftc_dma_t dma,
  // Observed data
  output logic got,
  output logic [7:0] last_rx
);
  import uftc_pkg::*;
  logic pace;
  // One pop per request, never on two edges in a row
  always_ff @(posedge mclk) begin
    if (srst) begin
      dma <= '0;
      pace <= 1'b0;
      got <= 1'b0;
      last_rx <= 8'h00;
    end else begin
      pace <= ~pace;
      dma.rx_ack <= en & rx_dma_req & ~dma.rx_ack & (~slow | pace);
      if (dma.rx_ack) begin
        got <= 1'b1;
        last_rx <= rx_dma_data;
      end
    end
  end
endmodule : uftc_host_dma

// ---- dv/testbench.sv ----
// Self-checking bench for time-outs, deferral, fallback and pins
`timescale 1ns/100ps
module testbench;
  import uftc_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  uftc_bus_t bus = '0;
  logic rx_load = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic char_tick = 1'b0;
  logic tx_pop = 1'b0;
  logic tx_idle = 1'b1;
  logic rx_act = 1'b0;
  logic dma_en = 1'b0;
  logic [2:0] pin_ext = 3'b010;
  logic id_pin = 1'b1;
  logic [7:0] rdata, tx_data, rx_dma_data, last_rx;
  logic tx_valid, rx_dma_req, rx_irq, ext_mode, got;
  logic [2:0] op_mode, sel_out, sel_oe_n;
  logic [15:0] baud_divisor;
  logic [1:0] prescale_sel;
  uftc_dma_t dma;
  wire [2:0] pin_lvl = (sel_oe_n & pin_ext) | (~sel_oe_n & sel_out);
  int error_cnt = 0;
  int n_tests = 0;

  always #25 mclk = ~mclk;

  uftc_top #(.FIFO_AW(5)) dut (.mclk(mclk), .srst(srst), .bus(bus),
    .rdata(rdata), .rx_load(rx_load), .rx_byte(rx_byte),
    .char_tick(char_tick), .rx_went_active(rx_act), .tx_pop(tx_pop),
    .tx_idle(tx_idle), .tx_valid(tx_valid), .tx_data(tx_data), .dma(dma),
    .rx_dma_req(rx_dma_req), .rx_dma_data(rx_dma_data), .rx_irq(rx_irq),
    .ext_mode(ext_mode), .op_mode(op_mode), .baud_divisor(baud_divisor),
    .prescale_sel(prescale_sel), .xcvr_sel_in(pin_lvl),
    .xcvr_id_input(id_pin), .xcvr_sel_out(sel_out),
    .xcvr_sel_oe_n(sel_oe_n));

  uftc_host_dma host (.mclk(mclk), .srst(srst), .en(dma_en), .slow(1'b1),
    .rx_dma_req(rx_dma_req), .rx_dma_data(rx_dma_data), .dma(dma),
    .got(got), .last_rx(last_rx));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("wait limit reached");
      conclude();
    end
  endtask : bound

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic bsel(input logic [1:0] b);
    wr(OFF_LCR, (b == BANK0) ? 8'h00 : ((b == BANK1) ? 8'h80 : 8'hC0));
  endtask : bsel

  task automatic ld(input logic [7:0] b);
    @(posedge mclk);
    rx_load <= 1'b1;
    rx_byte <= b;
    @(posedge mclk);
    rx_load <= 1'b0;
  endtask : ld

  task automatic chars;
    repeat (5) begin
      @(posedge mclk);
      char_tick <= 1'b1;
      @(posedge mclk);
      char_tick <= 1'b0;
    end
    #1;
  endtask : chars

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  initial begin
    int n;
    logic [7:0] d;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    cyc(1);
    chk("pin enables", sel_oe_n, 3'b111);
    chk("extended", ext_mode, 1'b0);
    $display("reset test done");
    // Queue on, threshold 4, data-ready enabled
    wr(OFF_EIR, 8'h41);
    wr(OFF_IER, 8'h01);
    ld(8'hA1);
    ld(8'hA2);
    cyc(1400);
    chk("irq before chars", rx_irq, 1'b0);
    chars();
    cyc(3);
    chk("irq on time-out", rx_irq, 1'b1);
    cyc(300);
    chk("irq held", rx_irq, 1'b1);
    rd(OFF_DATA, d);
    chk("rx head", d, 8'hA1);
    cyc(2);
    chk("irq after read", rx_irq, 1'b0);
    rd(OFF_DATA, d);
    chk("rx second", d, 8'hA2);
    $display("time-out A test done");
    bsel(BANK2);
    wr(3'h2, 8'h01);
    cyc(1);
    chk("extended on", ext_mode, 1'b1);
    bsel(BANK0);
    wr(OFF_MCR, 8'h04);
    ld(8'hB1);
    chars();
    for (n = 0; n < 50 && rx_dma_req !== 1'b1; n++) cyc(1);
    bound(n, 50);
    chk("irq on event B", rx_irq, 1'b0);
    cyc(1400);
    rd(OFF_ASC, d);
    chk("aux time-out", d[ASC_TO], 1'b1);
    chk("irq on event A", rx_irq, 1'b1);
    bsel(BANK2);
    @(posedge mclk) dma_en <= 1'b1;
    for (n = 0; n < 20 && got !== 1'b1; n++) cyc(1);
    bound(n, 20);
    chk("dma byte", last_rx, 8'hB1);
    @(posedge mclk) dma_en <= 1'b0;
    cyc(2);
    chk("irq after dma", rx_irq, 1'b0);
    chk("dma req after pop", rx_dma_req, 1'b0);
    $display("time-out B test done");
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    wr(3'h4, 8'h10);
    cyc(1);
    chk("alt divisor", baud_divisor, 16'h1234);
    chk("no fallback", ext_mode, 1'b1);
    chk("prescaler set", prescale_sel, 2'h1);
    bsel(BANK0);
    wr(OFF_MCR, 8'h40);
    cyc(1);
    chk("low-rate ir", op_mode, MODE_SIR);
    bsel(BANK1);
    rd(3'h0, d);
    chk("legacy low", d, 8'h34);
    cyc(1);
    chk("fallback ext", ext_mode, 1'b0);
    chk("fallback prescaler", prescale_sel, PRESC_13);
    chk("ir mode kept", op_mode, MODE_SIR);
    $display("fallback test done");
    bsel(BANK2);
    wr(3'h4, 8'h80);
    bsel(BANK1);
    wr(3'h0, 8'h5A);
    rd(3'h0, d);
    chk("scratch", d, 8'h5A);
    chk("divisor kept", baud_divisor, 16'h1234);
    $display("lock test done");
    bsel(BANK2);
    wr(3'h6, 8'h60);
    wr(3'h5, 8'h05);
    cyc(1);
    chk("pin levels", sel_out, 3'b101);
    chk("all driving", sel_oe_n, 3'b000);
    wr(3'h6, 8'h40);
    cyc(4);
    chk("pin0 only", sel_oe_n, 3'b110);
    rd(3'h7, d);
    chk("pin status", d, 8'h0B);
    // Presets: UART 011, infrared 110, automatic selection on
    wr(3'h5, 8'h35);
    wr(3'h6, 8'hE6);
    $display("pin test done");
    wr(3'h2, 8'h01);
    bsel(BANK0);
    wr(OFF_EIR, 8'h01);
    wr(OFF_MCR, 8'h10);
    for (n = 0; n < 3; n++) wr(OFF_DATA, 8'h70 + 8'(n));
    cyc(2);
    chk("deferred", tx_valid, 1'b0);
    chk("auto uart levels", sel_out, 3'b011);
    for (n = 0; n < 1500 && tx_valid !== 1'b1; n++) cyc(1);
    bound(n, 1500);
    chk("idle release late", 16'(n >= 1200), 16'h0001);
    chk("tx head", tx_data, 8'h70);
    repeat (3) begin
      @(posedge mclk) tx_pop <= 1'b1;
      @(posedge mclk) tx_pop <= 1'b0;
    end
    cyc(2);
    for (n = 0; n < 14; n++) begin
      wr(OFF_DATA, 8'(n));
      cyc(1);
      chk("level release", tx_valid, 1'(n == 13));
    end
    $display("deferral test done");
    // Consumer-infrared: threshold 4, receiver goes active first
    wr(OFF_EIR, 8'h41);
    wr(OFF_MCR, 8'h80);
    @(posedge mclk) rx_act <= 1'b1;
    @(posedge mclk) rx_act <= 1'b0;
    ld(8'hC1);
    cyc(1400);
    chk("irq while active", rx_irq, 1'b0);
    chk("auto ir levels", sel_out, 3'b110);
    rd(OFF_ASC, d);
    chk("active flag", d[ASC_ACT], 1'b1);
    wr(OFF_ASC, 8'h02);
    cyc(1200);
    chk("irq before idle time", rx_irq, 1'b0);
    cyc(200);
    chk("irq on cir time-out", rx_irq, 1'b1);
    rd(OFF_ASC, d);
    chk("aux time-out cir", d[ASC_TO], 1'b1);
    repeat (3) ld(8'hC2);
    rd(OFF_ASC, d);
    chk("aux time-out at level", d[ASC_TO], 1'b0);
    $display("consumer-ir test done");
    conclude();
  end
endmodule : testbench
